/* verilog/fws_consts.svh */
// Constants for the flash write-status host controller
`ifndef FWS_CONSTS_SVH
`define FWS_CONSTS_SVH
`define FWS_REG_CTRL 8'h00
`define FWS_REG_ADDR 8'h04
`define FWS_REG_WDATA 8'h08
`define FWS_REG_STATUS 8'h0C
`define FWS_REG_RDATA 8'h10
`define FWS_CMD_NONE 3'h0
`define FWS_CMD_PROG 3'h1
`define FWS_CMD_SECT 3'h2
`define FWS_CMD_ADDSECT 3'h3
`define FWS_CMD_CHIP 3'h4
`define FWS_CMD_RESET 3'h5
`define FWS_CMD_READ 3'h6
`define FWS_BIT_POLL 7
`define FWS_BIT_TOGGLE 6
`define FWS_BIT_FAIL 5
`define FWS_BIT_TIMER 3
`define FWS_ADDR_W 17
`define FWS_STROBE_CYC 4'h3
`define FWS_LEN_ONE 3'h1
`define FWS_LEN_PROG 3'h4
`define FWS_LEN_ERASE 3'h6
`define FWS_RES_OK 2'h1
`define FWS_RES_FAIL 2'h2
`define FWS_RES_REJECT 2'h3
`define FWS_UNLOCK_A1 17'h0_5555
`define FWS_UNLOCK_A2 17'h0_2AAA
`define FWS_UNLOCK_D1 8'hAA
`define FWS_UNLOCK_D2 8'h55
`define FWS_CD_PROG 8'hA0
`define FWS_CD_ERASE 8'h80
`define FWS_CD_CHIP 8'h10
`define FWS_CD_SECT 8'h30
`define FWS_CD_RESET 8'hF0
`endif

/* verilog/fws_pkg.sv */
// Types for the flash write-status host controller
package fws_pkg;
    typedef enum logic [3:0] {
        FWS_IDLE = 4'h0,
        FWS_WRITE = 4'h1,
        FWS_READ1 = 4'h2,
        FWS_READ2 = 4'h3,
        FWS_JUDGE = 4'h4,
        FWS_DONE = 4'h5,
        FWS_PRECHK = 4'h6
    } fws_state_type;
endpackage

/* verilog/fws_host.sv */
// Host controller that sequences flash program and erase and polls status
`include "fws_consts.svh"
module fws_host (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [16:0] flashAddr,
    output logic [7:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [7:0] flashDqIn,
    output logic flashCe_n,
    output logic flashOe_n,
    output logic flashWe_n
);
    import fws_pkg::*;

    // Only defined command codes start work; undefined codes are dropped
    function automatic logic isWriteCmd(input logic [2:0] c);
        isWriteCmd = (c >= `FWS_CMD_PROG) && (c <= `FWS_CMD_READ);
    endfunction

    fws_state_type state, next_state;
    logic [2:0] cmd, next_cmd;
    logic [16:0] opAddr, next_opAddr;
    logic [7:0] opData, next_opData;
    logic [2:0] seqIdx, next_seqIdx;
    logic [2:0] seqLen, next_seqLen;
    logic [3:0] cnt, next_cnt;
    logic [7:0] first, next_first;
    logic [7:0] rdData, next_rdData;
    logic [1:0] result, next_result;
    logic timerSeen, next_timerSeen;
    logic busy, next_busy;
    logic [16:0] pinAddr, next_pinAddr;
    logic [7:0] pinDq, next_pinDq;
    logic pinOe, next_pinOe, pinCe_n, next_pinCe_n;
    logic pinOe_n, next_pinOe_n, pinWe_n, next_pinWe_n;
    logic [7:0] dqMeta, dqSync;

    // AHB-Lite data phase capture
    logic wPend;
    logic [7:0] wAddr;
    logic [31:0] next_hrdata;
    logic go;

    // Two flops on the pin data before any logic reads it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dqMeta <= 8'h00;
            dqSync <= 8'h00;
        end else begin
            dqMeta <= flashDqIn;
            dqSync <= dqMeta;
        end
    end

    // Bus slave always ready and OKAY; register writes land one cycle after address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wPend <= 1'b0;
            wAddr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wPend <= hsel && hready && htrans[1] && hwrite;
            wAddr <= haddr[7:0];
            hrdata <= next_hrdata;
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign go = wPend && (wAddr == `FWS_REG_CTRL) && !busy && isWriteCmd(hwdata[2:0]);

    // Read mux; data ready in the data phase following the address phase
    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                `FWS_REG_CTRL: next_hrdata = {29'h0000_0000, cmd};
                `FWS_REG_ADDR: next_hrdata = {15'h0000, opAddr};
                `FWS_REG_WDATA: next_hrdata = {24'h00_0000, opData};
                `FWS_REG_STATUS: next_hrdata = {28'h000_0000, timerSeen, busy, result};
                `FWS_REG_RDATA: next_hrdata = {24'h00_0000, rdData};
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Unlock and command byte for step i of the current sequence
    function automatic logic [24:0] seqStep(input logic [2:0] c, input logic [2:0] i,
                                            input logic [16:0] a, input logic [7:0] d);
        logic [24:0] s;
        s = {`FWS_UNLOCK_A1, `FWS_UNLOCK_D1};
        case (i)
            3'h0: s = (c == `FWS_CMD_RESET) ? {a, `FWS_CD_RESET}
                    : (c == `FWS_CMD_ADDSECT) ? {a, `FWS_CD_SECT}
                    : {`FWS_UNLOCK_A1, `FWS_UNLOCK_D1};
            3'h1: s = {`FWS_UNLOCK_A2, `FWS_UNLOCK_D2};
            3'h2: s = (c == `FWS_CMD_PROG) ? {`FWS_UNLOCK_A1, `FWS_CD_PROG}
                    : {`FWS_UNLOCK_A1, `FWS_CD_ERASE};
            3'h3: s = (c == `FWS_CMD_PROG) ? {a, d} : {`FWS_UNLOCK_A1, `FWS_UNLOCK_D1};
            3'h4: s = {`FWS_UNLOCK_A2, `FWS_UNLOCK_D2};
            3'h5: s = (c == `FWS_CMD_CHIP) ? {`FWS_UNLOCK_A1, `FWS_CD_CHIP}
                    : {a, `FWS_CD_SECT};
            default: s = {`FWS_UNLOCK_A1, `FWS_UNLOCK_D1};
        endcase
        seqStep = s;
    endfunction

    // Sequencer next state
    always_comb begin
        next_state = state;
        next_cmd = cmd;
        next_opAddr = opAddr;
        next_opData = opData;
        next_seqIdx = seqIdx;
        next_seqLen = seqLen;
        next_cnt = cnt;
        next_first = first;
        next_rdData = rdData;
        next_result = result;
        next_timerSeen = timerSeen;
        next_busy = busy;
        next_pinAddr = pinAddr;
        next_pinDq = pinDq;
        next_pinOe = pinOe;
        next_pinCe_n = pinCe_n;
        next_pinOe_n = pinOe_n;
        next_pinWe_n = pinWe_n;
        if (wPend && !busy && wAddr == `FWS_REG_ADDR) next_opAddr = hwdata[16:0];
        if (wPend && !busy && wAddr == `FWS_REG_WDATA) next_opData = hwdata[7:0];
        case (state)
            FWS_IDLE: begin
                if (go) begin
                    next_cmd = hwdata[2:0];
                    next_busy = 1'b1;
                    next_result = 2'h0;
                    next_seqIdx = 3'h0;
                    next_cnt = 4'h0;
                    case (hwdata[2:0])
                        `FWS_CMD_RESET, `FWS_CMD_ADDSECT: next_seqLen = `FWS_LEN_ONE;
                        `FWS_CMD_PROG: next_seqLen = `FWS_LEN_PROG;
                        default: next_seqLen = `FWS_LEN_ERASE;
                    endcase
                    // Added sector checks the timer before the command
                    if (hwdata[2:0] == `FWS_CMD_ADDSECT) next_state = FWS_PRECHK;
                    else if (hwdata[2:0] == `FWS_CMD_READ) next_state = FWS_READ1;
                    else next_state = FWS_WRITE;
                end
            end
            FWS_PRECHK: begin
                // Timer is always read; command spacing is never assumed
                next_first = 8'h00;
                next_state = FWS_READ1;
            end
            FWS_WRITE: begin
                // Strobe low for three cycles, then high for four
                {next_pinAddr, next_pinDq} = seqStep(cmd, seqIdx, opAddr, opData);
                next_pinOe = 1'b1;
                next_pinCe_n = 1'b0;
                next_pinOe_n = 1'b1;
                next_cnt = cnt + 4'h1;
                next_pinWe_n = (cnt < `FWS_STROBE_CYC) ? 1'b0 : 1'b1;
                if (cnt == (`FWS_STROBE_CYC + `FWS_STROBE_CYC)) begin
                    next_cnt = 4'h0;
                    next_pinCe_n = 1'b1;
                    next_seqIdx = seqIdx + 3'h1;
                    if (seqIdx + 3'h1 == seqLen) begin
                        next_pinOe = 1'b0;
                        // Reset and plain read need no polling
                        if (cmd == `FWS_CMD_RESET) next_state = FWS_DONE;
                        else next_state = FWS_READ1;
                    end
                end
            end
            FWS_READ1, FWS_READ2: begin
                // Valid address: program address or sector in erase
                next_pinAddr = opAddr;
                next_pinOe = 1'b0;
                next_pinCe_n = 1'b0;
                next_pinOe_n = 1'b0;
                next_cnt = cnt + 4'h1;
                // Wait twice the strobe count, six cycles, so data clears the two synchroniser flops before sampling
                if (cnt == (`FWS_STROBE_CYC + `FWS_STROBE_CYC)) begin
                    next_cnt = 4'h0;
                    next_pinCe_n = 1'b1;
                    next_pinOe_n = 1'b1;
                    if (cmd == `FWS_CMD_READ) begin
                        next_rdData = dqSync;
                        next_state = FWS_DONE;
                    end else if (state == FWS_READ1) begin
                        next_first = dqSync;
                        next_state = FWS_READ2;
                    end else begin
                        next_rdData = dqSync;
                        next_state = FWS_JUDGE;
                    end
                end
            end
            FWS_JUDGE: begin
                next_state = FWS_READ1;
                if (cmd == `FWS_CMD_ADDSECT && seqIdx == 3'h0) begin
                    // Pre-check: timer already high means erase began
                    if (rdData[`FWS_BIT_TIMER]) begin
                        next_result = `FWS_RES_REJECT;
                        next_state = FWS_DONE;
                    end else begin
                        next_state = FWS_WRITE;
                    end
                end else if (first[`FWS_BIT_TOGGLE] == rdData[`FWS_BIT_TOGGLE]) begin
                    // Toggle stopped: operation finished successfully
                    next_result = `FWS_RES_OK;
                    next_state = FWS_DONE;
                end else if ((cmd == `FWS_CMD_SECT || cmd == `FWS_CMD_ADDSECT)
                             && !rdData[`FWS_BIT_TIMER]) begin
                    // Window still open; report it so software may add sectors
                    next_timerSeen = 1'b0;
                    next_result = `FWS_RES_OK;
                    next_state = FWS_DONE;
                end else if (cmd == `FWS_CMD_ADDSECT && rdData[`FWS_BIT_TIMER]
                             && !timerSeen) begin
                    // Timer now high after the add: command may be lost
                    next_timerSeen = 1'b1;
                    next_result = `FWS_RES_REJECT;
                    next_state = FWS_DONE;
                end else if (rdData[`FWS_BIT_FAIL]) begin
                    // Recheck toggle once more, it may stop as the fail bit rises
                    if (first[`FWS_BIT_FAIL]) begin
                        next_result = `FWS_RES_FAIL;
                        next_state = FWS_DONE;
                    end
                end else begin
                    next_timerSeen = rdData[`FWS_BIT_TIMER] && cmd != `FWS_CMD_PROG;
                end
            end
            FWS_DONE: begin
                next_busy = 1'b0;
                next_cmd = `FWS_CMD_NONE;
                next_pinCe_n = 1'b1;
                next_pinOe_n = 1'b1;
                next_pinWe_n = 1'b1;
                next_state = FWS_IDLE;
            end
            default: next_state = FWS_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FWS_IDLE;
            cmd <= `FWS_CMD_NONE;
            opAddr <= 17'h0_0000;
            opData <= 8'h00;
            seqIdx <= 3'h0;
            seqLen <= 3'h0;
            cnt <= 4'h0;
            first <= 8'h00;
            rdData <= 8'h00;
            result <= 2'h0;
            timerSeen <= 1'b0;
            busy <= 1'b0;
            pinAddr <= 17'h0_0000;
            pinDq <= 8'h00;
            pinOe <= 1'b0;
            pinCe_n <= 1'b1;
            pinOe_n <= 1'b1;
            pinWe_n <= 1'b1;
        end else begin
            state <= next_state;
            cmd <= next_cmd;
            opAddr <= next_opAddr;
            opData <= next_opData;
            seqIdx <= next_seqIdx;
            seqLen <= next_seqLen;
            cnt <= next_cnt;
            first <= next_first;
            rdData <= next_rdData;
            result <= next_result;
            timerSeen <= next_timerSeen;
            busy <= next_busy;
            pinAddr <= next_pinAddr;
            pinDq <= next_pinDq;
            pinOe <= next_pinOe;
            pinCe_n <= next_pinCe_n;
            pinOe_n <= next_pinOe_n;
            pinWe_n <= next_pinWe_n;
        end
    end

    // Pins straight from flops
    assign flashAddr = pinAddr;
    assign flashDqOut = pinDq;
    assign flashDqOe = pinOe;
    assign flashCe_n = pinCe_n;
    assign flashOe_n = pinOe_n;
    assign flashWe_n = pinWe_n;
endmodule

/* dv/fws_host_asserts.sv */
// Port checker for the flash status host, bound to its top module
module fws_host_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [16:0] flashAddr,
    input wire logic [7:0] flashDqOut,
    input wire logic flashDqOe,
    input wire logic flashCe_n,
    input wire logic flashOe_n,
    input wire logic flashWe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Strobe shapes: a fixed width so every cycle is seen by the device
    sequence weLow3;
        !flashWe_n [*3] ##1 flashWe_n;
    endsequence
    sequence oeLow6;
        !flashOe_n [*6] ##1 flashOe_n;
    endsequence
    AST_BUS_OKAY: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus answer not zero-wait OKAY");
    AST_WE_PULSE: assert property ($fell(flashWe_n) |-> weLow3)
        else $error("write strobe width wrong");
    AST_OE_PULSE: assert property ($fell(flashOe_n) |-> oeLow6)
        else $error("read strobe width wrong");
    AST_STROBE_CE: assert property (!(flashWe_n && flashOe_n) |-> !flashCe_n)
        else $error("strobe without chip enable");
    AST_WR_HOLD: assert property ((!flashWe_n && !$past(flashWe_n))
        |-> ($stable(flashAddr) && $stable(flashDqOut))) else $error("write lost its operands");
    AST_RD_HOLD: assert property ((!flashOe_n && !$past(flashOe_n))
        |-> $stable(flashAddr)) else $error("read address moved");
    AST_WR_DRIVE: assert property (!flashWe_n |-> flashDqOe)
        else $error("write without driving data");
    AST_NO_FIGHT: assert property (flashDqOe |-> flashOe_n)
        else $error("host drives while device outputs");
endmodule
bind fws_host fws_host_asserts u_fws_host_asserts (.clk(clk), .rst_n(rst_n),
    .hreadyout(hreadyout), .hresp(hresp), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe), .flashCe_n(flashCe_n), .flashOe_n(flashOe_n), .flashWe_n(flashWe_n));

/* dv/fws_flash_model.sv */
// Behavioural flash device answering the host with write status
module fws_flash_model #(
    parameter int WIN_NS = 50000,
    parameter int PROG_NS = 4000,
    parameter int ERASE_NS = 20000
) (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [16:0] addr,
    input wire logic [7:0] busIn,
    output logic [7:0] dqOut
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] pd, mask, lastOut;
    logic [16:0] pa;
    logic [2:0] st, n; // st: 0 array, 1 program, 2 window, 3 erase
    logic tog, fail, bad;
    realtime t0;
    // Array starts erased and idle
    initial begin
        {st, n, tog, fail, lastOut} = '0;
        for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
    end
    // Released bus shows the inverse of the last byte, so stale data never passes
    always_comb begin
        if (ce_n || oe_n) dqOut = ~lastOut;
        else if (st == 3'h1) dqOut = {~pd[7], tog, fail, 1'b0, tog, 3'h0};
        else if (st == 3'h2) dqOut = {1'b0, tog, 6'h00};
        else if (st == 3'h3) dqOut = {1'b0, tog, 2'h0, 1'b1, 3'h0};
        else dqOut = mem[{addr[16:14], addr[4:0]}];
    end
    always @(dqOut) if (!ce_n && !oe_n) lastOut = dqOut;
    // Each finished read cycle flips the toggle bit while busy
    always @(posedge oe_n) if (st != 3'h0) tog = ~tog;
    // Commands land at the rising edge of the write strobe
    always @(posedge we_n) begin
        if (ce_n || st == 3'h3 || (st == 3'h1 && !fail)) begin
            n = 3'h0;
        end else if (st == 3'h2 && busIn == 8'h30) begin
            mask[addr[16:14]] = 1'b1;
            t0 = $realtime;
        end else if (st != 3'h0 || busIn == 8'hF0) begin
            st = 3'h0;
            fail = 1'b0;
            n = 3'h0;
        end else begin
            case (n)
                3'h2: n = (busIn == 8'hA0) ? 3'h3 : (busIn == 8'h80) ? 3'h4 : 3'h0;
                3'h3: begin
                    pa = addr;
                    pd = busIn;
                    bad = |(busIn & ~mem[{addr[16:14], addr[4:0]}]);
                    st = 3'h1;
                    n = 3'h0;
                end
                3'h6: begin
                    mask = (busIn == 8'h10) ? 8'hFF : 8'h01 << addr[16:14];
                    st = (busIn == 8'h10) ? 3'h3 : (busIn == 8'h30) ? 3'h2 : 3'h0;
                    n = 3'h0;
                end
                3'h0, 3'h4: n = (busIn == 8'hAA) ? n + 3'h1 : 3'h0;
                default: n = (busIn == 8'h55) ? n + 3'h1 : 3'h0;
            endcase
            t0 = $realtime;
        end
    end
    // Internal timers run on elapsed time, as the device has no clock
    always #100 begin
        if (st == 3'h2 && $realtime - t0 >= WIN_NS) begin
            st = 3'h3;
            t0 = $realtime;
        end else if (st == 3'h3 && $realtime - t0 >= ERASE_NS) begin
            for (int i = 0; i < 256; i++) if (mask[i[7:5]]) mem[i] = 8'hFF;
            st = 3'h0;
        end else if (st == 3'h1 && !fail && $realtime - t0 >= PROG_NS) begin
            fail = bad;
            if (!bad) mem[{pa[16:14], pa[4:0]}] = pd;
            if (!bad) st = 3'h0;
        end
    end
endmodule

/* dv/fws_host_tb_top.sv */
// Bench driving the flash status host over AHB against a device model
`include "fws_consts.svh"
module fws_host_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd;
    logic [16:0] flashAddr;
    logic [7:0] flashDqOut, flashDqIn, devDq;
    logic hreadyout, hresp, flashDqOe, flashCe_n, flashOe_n, flashWe_n;
    int errorCnt = 0;
    int checks = 0;
    int cycles = 0;
    always #20 clk = ~clk;
    // Wire level of the data pins from both drivers
    assign flashDqIn = flashDqOe ? flashDqOut : devDq;
    fws_host u_fws_host (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flashAddr(flashAddr),
        .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(flashDqIn),
        .flashCe_n(flashCe_n), .flashOe_n(flashOe_n), .flashWe_n(flashWe_n));
    fws_flash_model u_fws_flash_model (.ce_n(flashCe_n), .oe_n(flashOe_n), .we_n(flashWe_n),
        .addr(flashAddr), .busIn(flashDqIn), .dqOut(devDq));
    task automatic conclude();
        $display("errors %0d checks %0d", errorCnt, checks);
        if (errorCnt == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One single AHB transfer; read data is taken at the closing edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Issue a command and poll until busy drops; only the timeout ends a hang
    task automatic cmd(input logic [16:0] a, input logic [7:0] d, input logic [2:0] c);
        xfer(1'b1, `FWS_REG_ADDR, {15'h0000, a});
        xfer(1'b1, `FWS_REG_WDATA, {24'h00_0000, d});
        xfer(1'b1, `FWS_REG_CTRL, {29'h0000_0000, c});
        do xfer(1'b0, `FWS_REG_STATUS, 32'h0000_0000); while (rd[2] !== 1'b0);
    endtask
    task automatic res(input logic [1:0] r);
        check(rd & 32'h0000_0003, {30'h0000_0000, r});
    endtask
    task automatic peek(input logic [16:0] a, input logic [31:0] exp);
        cmd(a, 8'h00, `FWS_CMD_READ);
        xfer(1'b0, `FWS_REG_RDATA, 32'h0000_0000);
        check(rd, exp);
    endtask
    // Cycle ceiling well above the longest erase sequence
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errorCnt++;
            conclude();
        end
    end
    // Program, failure and recovery, sector erase window, chip erase
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        xfer(1'b0, 8'h40, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        cmd(17'h0_0010, 8'h5A, `FWS_CMD_PROG);
        res(`FWS_RES_OK);
        cmd(17'h0_C010, 8'h12, `FWS_CMD_PROG);
        res(`FWS_RES_OK);
        peek(17'h0_0010, 32'h0000_005A);
        cmd(17'h0_0010, 8'hA5, `FWS_CMD_PROG);
        res(`FWS_RES_FAIL);
        cmd(17'h0_0000, 8'h00, `FWS_CMD_RESET);
        peek(17'h0_0010, 32'h0000_005A);
        cmd(17'h0_0010, 8'h00, `FWS_CMD_SECT);
        res(`FWS_RES_OK);
        check(rd & 32'h0000_0008, 32'h0000_0000);
        repeat (1000) @(posedge clk);
        cmd(17'h0_4010, 8'h00, `FWS_CMD_ADDSECT);
        res(`FWS_RES_OK);
        repeat (1000) @(posedge clk);
        cmd(17'h0_8010, 8'h00, `FWS_CMD_ADDSECT);
        res(`FWS_RES_OK);
        repeat (1300) @(posedge clk);
        cmd(17'h0_8010, 8'h00, `FWS_CMD_ADDSECT);
        res(`FWS_RES_REJECT);
        for (int i = 0; i < 200 && rd[7] !== 1'b1; i++) begin
            cmd(17'h0_4010, 8'h00, `FWS_CMD_READ);
            xfer(1'b0, `FWS_REG_RDATA, 32'h0000_0000);
        end
        check(rd, 32'h0000_00FF);
        peek(17'h0_0010, 32'h0000_00FF);
        peek(17'h0_C010, 32'h0000_0012);
        cmd(17'h0_0000, 8'h00, `FWS_CMD_CHIP);
        res(`FWS_RES_OK);
        check(rd & 32'h0000_0008, 32'h0000_0008);
        peek(17'h0_C010, 32'h0000_00FF);
        conclude();
    end
endmodule
